/* File: calrack_pkg.sv */
// Constants, types and register map of the calibration rack selector.
// Assumes a single 50 MHz clock and a 32-bit AHB-Lite register bus.
package calrack_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
   // Time the checkout equipment holds one code set, longest window
   localparam int unsigned HOLD_MS = 40;
   localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
   // Settling time of the synchronising stage, least time
   localparam int unsigned SETTLE_NS = 1000;
   localparam int unsigned SETTLE_CYC =
      (SETTLE_NS * CLK_PER_US + 999) / 1000;
   // Width of the internal clear pulse, least time
   localparam int unsigned CLEAR_NS = 1000;
   localparam int unsigned CLEAR_CYC =
      (CLEAR_NS * CLK_PER_US + 999) / 1000;

   ////////////////////////////////////////////////////////////////////////
   // Code widths and rack count
   localparam int unsigned MODE_W = 2;
   localparam int unsigned RACK_W = 6;
   localparam int unsigned CHAN_W = 5;
   localparam int unsigned RACKS = 14;
   localparam int unsigned MAP_DEPTH = 64;

   // Mode code values on the two input lines
   localparam logic [MODE_W-1:0] MODE_RUN = 2'h0;
   localparam logic [MODE_W-1:0] MODE_HIGH = 2'h1;
   localparam logic [MODE_W-1:0] MODE_LOW = 2'h2;

   // Rack code that selects every rack in the default table
   localparam logic [RACK_W-1:0] RACK_ALL = 6'h3F;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_SELECT = 8'h08;
   localparam logic [7:0] OFF_LAST = 8'h0C;
   localparam logic [7:0] OFF_MAP_INDEX = 8'h10;
   localparam logic [7:0] OFF_MAP_DATA = 8'h14;

   // Field positions
   localparam int unsigned CTRL_ENABLE_BIT = 0;
   localparam int unsigned CTRL_CLEAR_BIT = 1;
   localparam int unsigned ST_BUSY_BIT = 0;
   localparam int unsigned ST_CLEARING_BIT = 1;
   localparam int unsigned ST_DRIVING_BIT = 2;
   localparam int unsigned ST_EXPIRED_BIT = 3;
   localparam int unsigned LAST_MODE_LSB = 0;
   localparam int unsigned LAST_RACK_LSB = 8;
   localparam int unsigned LAST_CHAN_LSB = 16;

   // Reset values
   localparam logic CTRL_ENABLE_RST = 1'b1;

   // Bus constants
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [1:0] READ_WAIT = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic [MODE_W-1:0] mode;
      logic [RACK_W-1:0] rack;
      logic [CHAN_W-1:0] chan;
   } cal_cmd_t;

   typedef enum logic [1:0] {
      CAL_RUN,
      CAL_HIGH,
      CAL_LOW
   } cal_mode_t;

   typedef enum {
      ST_CLEAR,
      ST_IDLE,
      ST_SYNC,
      ST_DRIVE,
      ST_WAIT_DROP
   } seq_state_t;

endpackage

/* File: rack_map_mem.sv */
// Rack code to rack set table, 64 entries of 14 bits, two read ports.
// Assumes one clock; read data of both ports come out of registers.
`timescale 1ns/1ps
module rack_map_mem (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [calrack_pkg::RACK_W-1:0] a_addr,
   output logic [calrack_pkg::RACKS-1:0] a_data,
   input wire logic [calrack_pkg::RACK_W-1:0] b_addr,
   output logic [calrack_pkg::RACKS-1:0] b_data,
   input wire logic wr_en,
   input wire logic [calrack_pkg::RACK_W-1:0] wr_addr,
   input wire logic [calrack_pkg::RACKS-1:0] wr_data
);

   logic [calrack_pkg::RACKS-1:0] map_r [calrack_pkg::MAP_DEPTH];

   // Default entry: codes below the rack count pick one rack each,
   // the all-racks code picks every rack, the rest pick none
   function automatic logic [calrack_pkg::RACKS-1:0] default_entry(
      input int unsigned idx);
      logic [calrack_pkg::RACKS-1:0] ent;
      ent = '0;
      if (idx < calrack_pkg::RACKS) begin
         ent[idx] = 1'b1;
      end else if (idx == int'(calrack_pkg::RACK_ALL)) begin
         ent = '1;
      end
      return ent;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Table storage, loaded with defaults by reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < calrack_pkg::MAP_DEPTH; i++) begin
            map_r[i] <= default_entry(i);
         end
      end else if (wr_en) begin
         map_r[wr_addr] <= wr_data;
      end
   end

   // Registered read ports
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         a_data <= '0;
         b_data <= '0;
      end else begin
         a_data <= map_r[a_addr];
         b_data <= map_r[b_addr];
      end
   end

endmodule

/* File: calrack_sel.sv */
// Calibration rack selector: takes mode, rack and channel codes from the
// ground checkout equipment and drives rack select and broadcast lines.
// Assumes codes arrive synchronous to ref_clk and one AHB-Lite master.
//
// Notes on behaviour
// - Mode code arrives on two lines.
// - Mode decodes to one of high, low, run.
// - Mode arrival starts sync stage gating rack outputs.
// - Six-line rack code decoded through matrix.
// - Rack outputs idle without mode command.
// - Select lines normally high, chosen racks low.
// - Fourteen rack lines, one or many chosen.
// - Five-line channel code buffered to all selectors.
// - Power-up clear pulse resets all state.
`timescale 1ns/1ps
module calrack_sel #(
   parameter int unsigned HOLD_CYC = calrack_pkg::HOLD_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic cmd_present,
   input wire calrack_pkg::cal_cmd_t cal_cmd,
   output logic [calrack_pkg::RACKS-1:0] rack_sel_n,
   output logic cal_high,
   output logic cal_low,
   output logic cal_run,
   output logic [calrack_pkg::CHAN_W-1:0] chan_sel,
   output logic busy
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   calrack_pkg::seq_state_t state_r;
   logic [31:0] cnt_r;
   logic present_d_r;
   logic present_rise;
   logic sync_done;
   logic drive_end;
   calrack_pkg::cal_cmd_t last_r;
   logic enable_r;
   logic clr_req_r;
   logic [calrack_pkg::RACK_W-1:0] map_index_r;
   logic [calrack_pkg::RACKS-1:0] map_a;
   logic [calrack_pkg::RACKS-1:0] map_b;
   logic map_wr;
   logic accept;
   logic wr_pend_r;
   logic [7:0] addr_r;
   logic addr_ok_r;
   logic [1:0] rd_cnt_r;
   logic [31:0] rd_val;

   // Mode code to broadcast command; the unused code reads as run
   function automatic calrack_pkg::cal_mode_t decode_mode(
      input logic [calrack_pkg::MODE_W-1:0] code);
      calrack_pkg::cal_mode_t m;
      case (code)
         calrack_pkg::MODE_HIGH: m = calrack_pkg::CAL_HIGH;
         calrack_pkg::MODE_LOW: m = calrack_pkg::CAL_LOW;
         default: m = calrack_pkg::CAL_RUN;
      endcase
      return m;
   endfunction

   // Word-aligned register hit inside the slave window
   function automatic logic reg_hit(input logic [7:0] a,
                                    input logic [7:0] off);
      return a == off;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Sequencer events
   assign present_rise = cmd_present && !present_d_r;
   // Codes captured only after the settle time of the sync stage
   assign sync_done = (state_r == calrack_pkg::ST_SYNC) && cmd_present &&
      (cnt_r == 32'(calrack_pkg::SETTLE_CYC - 1));
   // Rack lines released when the mode command goes or the hold ends
   assign drive_end = clr_req_r || (state_r == calrack_pkg::ST_CLEAR) ||
      ((state_r == calrack_pkg::ST_DRIVE) &&
       (!cmd_present || cnt_r == 32'(HOLD_CYC - 1)));

   // Previous level of the mode-present line for arrival detection
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         present_d_r <= 1'b0;
      end else begin
         present_d_r <= cmd_present;
      end
   end

   // Sequencer: clear, wait for arrival, settle, drive, wait for drop
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= calrack_pkg::ST_CLEAR;
         cnt_r <= '0;
      end else if (clr_req_r) begin
         state_r <= calrack_pkg::ST_CLEAR;
         cnt_r <= '0;
      end else begin
         case (state_r)
            calrack_pkg::ST_CLEAR: begin
               if (cnt_r == 32'(calrack_pkg::CLEAR_CYC - 1)) begin
                  state_r <= calrack_pkg::ST_IDLE;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + 32'h1;
               end
            end
            calrack_pkg::ST_IDLE: begin
               // A code already standing at clear release is ignored
               if (present_rise && enable_r) begin
                  state_r <= calrack_pkg::ST_SYNC;
                  cnt_r <= '0;
               end
            end
            calrack_pkg::ST_SYNC: begin
               if (!cmd_present) begin
                  state_r <= calrack_pkg::ST_IDLE;
                  cnt_r <= '0;
               end else if (sync_done) begin
                  state_r <= calrack_pkg::ST_DRIVE;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + 32'h1;
               end
            end
            calrack_pkg::ST_DRIVE: begin
               if (!cmd_present) begin
                  state_r <= calrack_pkg::ST_IDLE;
                  cnt_r <= '0;
               end else if (drive_end) begin
                  state_r <= calrack_pkg::ST_WAIT_DROP;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + 32'h1;
               end
            end
            calrack_pkg::ST_WAIT_DROP: begin
               // Overlong code: wait for release before a new arrival
               if (!cmd_present) begin
                  state_r <= calrack_pkg::ST_IDLE;
               end
            end
            default: begin
               state_r <= calrack_pkg::ST_CLEAR;
               cnt_r <= '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output lines
   // Rack lines stay high; chosen racks go low after sync only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rack_sel_n <= '1;
      end else if (drive_end) begin
         rack_sel_n <= '1;
      end else if (sync_done) begin
         rack_sel_n <= ~map_a;
      end
   end

   // Mode broadcast: exactly one of high, low, run at any time
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cal_high <= 1'b0;
         cal_low <= 1'b0;
         cal_run <= 1'b1;
      end else if (drive_end) begin
         cal_high <= 1'b0;
         cal_low <= 1'b0;
         cal_run <= 1'b1;
      end else if (sync_done) begin
         cal_high <= decode_mode(cal_cmd.mode) ==
            calrack_pkg::CAL_HIGH;
         cal_low <= decode_mode(cal_cmd.mode) ==
            calrack_pkg::CAL_LOW;
         cal_run <= decode_mode(cal_cmd.mode) ==
            calrack_pkg::CAL_RUN;
      end
   end

   // Channel code passed through undecoded, captured with the others
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         chan_sel <= '0;
         last_r <= '0;
      end else if (state_r == calrack_pkg::ST_CLEAR) begin
         chan_sel <= '0;
         last_r <= '0;
      end else if (sync_done) begin
         chan_sel <= cal_cmd.chan;
         last_r <= cal_cmd;
      end
   end

   // Busy whenever the sequencer is not waiting for a new code
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy <= 1'b1;
      end else begin
         busy <= !(state_r == calrack_pkg::ST_IDLE && !present_rise);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Rack map; port a follows the live rack code so it is ready at sync
   rack_map_mem u_map (
      .ref_clk(ref_clk),
      .rst(rst),
      .a_addr(cal_cmd.rack),
      .a_data(map_a),
      .b_addr(map_index_r),
      .b_data(map_b),
      .wr_en(map_wr),
      .wr_addr(map_index_r),
      .wr_data(hwdata[calrack_pkg::RACKS-1:0])
   );

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: writes take no wait, reads take two
   assign accept = hsel && htrans[1] && hready;
   assign map_wr = wr_pend_r && addr_ok_r &&
      reg_hit(addr_r, calrack_pkg::OFF_MAP_DATA);

   // Address phase capture and data phase tracking
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         addr_r <= '0;
         addr_ok_r <= 1'b0;
         rd_cnt_r <= '0;
         hreadyout <= 1'b1;
      end else begin
         if (rd_cnt_r != 2'h0) begin
            rd_cnt_r <= rd_cnt_r - 2'h1;
            hreadyout <= rd_cnt_r == 2'h1;
         end
         if (accept) begin
            wr_pend_r <= hwrite;
            addr_r <= haddr[7:0];
            // Only aligned whole words in the low window are mapped
            addr_ok_r <= hsize == calrack_pkg::HSIZE_WORD &&
               haddr[31:8] == 24'h000000 && haddr[1:0] == 2'h0;
            if (!hwrite) begin
               rd_cnt_r <= calrack_pkg::READ_WAIT;
               hreadyout <= 1'b0;
            end
         end else if (hready) begin
            wr_pend_r <= 1'b0;
         end
      end
   end

   // Response is always OKAY
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // Control register and one-cycle soft clear request
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         enable_r <= calrack_pkg::CTRL_ENABLE_RST;
         clr_req_r <= 1'b0;
      end else if (wr_pend_r && addr_ok_r &&
                   reg_hit(addr_r, calrack_pkg::OFF_CTRL)) begin
         enable_r <= hwdata[calrack_pkg::CTRL_ENABLE_BIT];
         clr_req_r <= hwdata[calrack_pkg::CTRL_CLEAR_BIT];
      end else begin
         clr_req_r <= 1'b0;
      end
   end

   // Map index register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         map_index_r <= '0;
      end else if (wr_pend_r && addr_ok_r &&
                   reg_hit(addr_r, calrack_pkg::OFF_MAP_INDEX)) begin
         map_index_r <= hwdata[calrack_pkg::RACK_W-1:0];
      end
   end

   // Read multiplexer; unmapped addresses read as zero
   always_comb begin
      rd_val = '0;
      if (addr_ok_r) begin
         case (addr_r)
            calrack_pkg::OFF_CTRL:
               rd_val[calrack_pkg::CTRL_ENABLE_BIT] = enable_r;
            calrack_pkg::OFF_STATUS: begin
               rd_val[calrack_pkg::ST_BUSY_BIT] = busy;
               rd_val[calrack_pkg::ST_CLEARING_BIT] =
                  state_r == calrack_pkg::ST_CLEAR;
               rd_val[calrack_pkg::ST_DRIVING_BIT] =
                  state_r == calrack_pkg::ST_DRIVE;
               rd_val[calrack_pkg::ST_EXPIRED_BIT] =
                  state_r == calrack_pkg::ST_WAIT_DROP;
            end
            calrack_pkg::OFF_SELECT:
               rd_val[calrack_pkg::RACKS-1:0] = rack_sel_n;
            calrack_pkg::OFF_LAST: begin
               rd_val[calrack_pkg::LAST_MODE_LSB +: calrack_pkg::MODE_W] =
                  last_r.mode;
               rd_val[calrack_pkg::LAST_RACK_LSB +: calrack_pkg::RACK_W] =
                  last_r.rack;
               rd_val[calrack_pkg::LAST_CHAN_LSB +: calrack_pkg::CHAN_W] =
                  last_r.chan;
            end
            calrack_pkg::OFF_MAP_INDEX:
               rd_val[calrack_pkg::RACK_W-1:0] = map_index_r;
            calrack_pkg::OFF_MAP_DATA:
               rd_val[calrack_pkg::RACKS-1:0] = map_b;
            default: rd_val = '0;
         endcase
      end
   end

   // Read data registered in the last wait cycle of a read
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hrdata <= '0;
      end else if (rd_cnt_r == 2'h1) begin
         hrdata <= rd_val;
      end
   end

endmodule

/* File: calrack_sel_assertions.sv */
// Port-level checker for the calibration rack selector.
// Assumes it is bound onto calrack_sel with the same HOLD_CYC.
`timescale 1ns/1ps
module calrack_sel_assertions #(
   parameter int unsigned HOLD_CYC = calrack_pkg::HOLD_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cmd_present,
   input wire calrack_pkg::cal_cmd_t cal_cmd,
   input wire logic [calrack_pkg::RACKS-1:0] rack_sel_n,
   input wire logic cal_high,
   input wire logic cal_low,
   input wire logic cal_run,
   input wire logic [calrack_pkg::CHAN_W-1:0] chan_sel,
   input wire logic busy
);
   logic [7:0] hi_cnt_r;
   logic [31:0] drive_cnt_r;
   logic idle_w;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   //////////////////////////////////////////////////////////////
   // Lines at rest: every rack line high (none selected), run mode
   assign idle_w = (&rack_sel_n) && cal_run;

   // Cycles with the command present; saturates to stay small
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hi_cnt_r <= 8'h00;
      end else if (!cmd_present) begin
         hi_cnt_r <= 8'h00;
      end else if (hi_cnt_r != 8'hFF) begin
         hi_cnt_r <= hi_cnt_r + 8'h01;
      end
   end

   // Cycles the lines stay away from rest
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         drive_cnt_r <= 32'h0;
      end else begin
         drive_cnt_r <= idle_w ? 32'h0 : drive_cnt_r + 32'h1;
      end
   end

   mode_one_hot_a: assert property (
      $onehot({cal_high, cal_low, cal_run}))
      else $error("mode outputs not one-hot");
   idle_rest_a: assert property (!busy |-> idle_w)
      else $error("lines driven while idle");
   drop_rest_a: assert property (!cmd_present |=> idle_w)
      else $error("lines held after command drop");
   high_cause_a: assert property ($rose(cal_high) |->
      $past(cal_cmd.mode) == calrack_pkg::MODE_HIGH)
      else $error("high mode without high code");
   // A clear stage zeroes the channel lines while busy
   chan_copy_a: assert property ($changed(chan_sel) |->
      chan_sel == $past(cal_cmd.chan) || (chan_sel == 5'h00 && busy))
      else $error("channel lines differ from code");
   settle_len_a: assert property (($fell(&rack_sel_n) ||
      $rose(cal_high) || $rose(cal_low)) |->
      hi_cnt_r >= 8'(calrack_pkg::SETTLE_CYC + 1))
      else $error("lines moved before settling");
   settle_quiet_a: assert property ($rose(cmd_present) && !busy |=>
      idle_w [*8])
      else $error("lines moved at arrival");
   hold_limit_a: assert property (drive_cnt_r <= HOLD_CYC + 32'h2)
      else $error("lines held past hold time");
   clear_hold_a: assert property ($fell(rst) |-> (busy && idle_w) [*8])
      else $error("clear stage too short");

   cover property ($fell(&rack_sel_n));
   cover property ($rose(cal_low));
   cover property (drive_cnt_r == HOLD_CYC);
endmodule

/* File: ckout_equipment.sv */
// Checkout equipment model: presents one code set on request.
// Assumes the bench raises go for one cycle while done is high.
`timescale 1ns/1ps
module ckout_equipment (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic go,
   input wire calrack_pkg::cal_cmd_t cmd_in,
   input wire logic [15:0] hold_len,
   output logic cmd_present,
   output calrack_pkg::cal_cmd_t cal_cmd,
   output logic done
);
   logic [15:0] left_r;

   //////////////////////////////////////////////////////////////
   // All codes move on one edge; released lines toggle so a stale
   // value can never pass for a held one
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmd_present <= 1'b0;
         cal_cmd <= '0;
         left_r <= 16'h0000;
         done <= 1'b1;
      end else if (go && done) begin
         cmd_present <= 1'b1;
         cal_cmd <= cmd_in;
         left_r <= hold_len;
         done <= 1'b0;
      end else if (!done && left_r != 16'h0001) begin
         left_r <= left_r - 16'h0001;
      end else begin
         cmd_present <= 1'b0;
         cal_cmd <= calrack_pkg::cal_cmd_t'(~cal_cmd);
         done <= 1'b1;
      end
   end
endmodule

/* File: calrack_sel_tb_top.sv */
// Testbench for the calibration rack selector.
// Assumes the default rack table and a shortened hold time.
`timescale 1ns/1ps
module calrack_sel_tb_top;
   localparam int unsigned HOLD = 200;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic cmd_present;
   calrack_pkg::cal_cmd_t cal_cmd;
   logic [13:0] rack_sel_n;
   logic cal_high;
   logic cal_low;
   logic cal_run;
   logic [4:0] chan_sel;
   logic busy;
   logic done;
   logic go = 1'b0;
   calrack_pkg::cal_cmd_t cmd_in = '0;
   logic [15:0] hold_len = 16'h0001;
   logic [31:0] rd;
   calrack_pkg::cal_cmd_t c;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;

   //////////////////////////////////////////////////////////////
   // 50 MHz clock
   always #10 ref_clk = ~ref_clk;

   calrack_sel #(.HOLD_CYC(HOLD)) dut (.ref_clk(ref_clk), .rst(rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(calrack_pkg::HSIZE_WORD), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .cmd_present(cmd_present), .cal_cmd(cal_cmd),
      .rack_sel_n(rack_sel_n), .cal_high(cal_high), .cal_low(cal_low),
      .cal_run(cal_run), .chan_sel(chan_sel), .busy(busy));

   ckout_equipment eq (.ref_clk(ref_clk), .rst(rst), .go(go),
      .cmd_in(cmd_in), .hold_len(hold_len), .cmd_present(cmd_present),
      .cal_cmd(cal_cmd), .done(done));

   task automatic complete_run;
      begin
         $display("compares %0d mismatches %0d", cmp_count, err_count);
         if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask

   // Hang guard, far above the expected few thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         complete_run;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         cmp_count++;
         if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %h expected %h", $time, seen, exp);
         end
      end
   endtask

   // Waits for hready at an edge; read data is taken at that edge
   task automatic bus_wait;
      begin
         @(negedge ref_clk);
         while (hreadyout !== 1'b1) begin
            @(negedge ref_clk);
         end
         rd = hrdata;
         @(posedge ref_clk);
      end
   endtask

   // One single-word transfer; read result lands in rd
   task automatic bus(input logic [7:0] off, input logic wr,
         input logic [31:0] d);
      begin
         @(posedge ref_clk);
         hsel <= 1'b1;
         haddr <= {24'h0, off};
         hwrite <= wr;
         htrans <= 2'h2;
         bus_wait;
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         bus_wait;
         check(32'(hresp), 32'h0);
      end
   endtask

   function automatic logic [2:0] mexp(input logic [1:0] m);
      begin
         mexp = (m == calrack_pkg::MODE_HIGH) ? 3'h4 :
            (m == calrack_pkg::MODE_LOW) ? 3'h2 : 3'h1;
      end
   endfunction

   // One command; act says whether the lines should respond
   task automatic do_cmd(input calrack_pkg::cal_cmd_t k,
         input logic [15:0] len, input logic [13:0] sel, input logic act);
      begin
         @(posedge ref_clk);
         cmd_in <= k;
         hold_len <= len;
         go <= 1'b1;
         @(posedge ref_clk);
         go <= 1'b0;
         repeat (60) @(negedge ref_clk);
         check(32'(rack_sel_n), 32'(sel));
         check(32'({cal_high, cal_low, cal_run}),
            32'(act ? mexp(k.mode) : 3'h1));
         if (act) begin
            check(32'(chan_sel), 32'(k.chan));
         end
         if (len > 16'h00FA) begin
            repeat (210) @(negedge ref_clk);
            check(32'({rack_sel_n, cal_run}), 32'h7FFF);
         end
         while (done !== 1'b1) begin
            @(negedge ref_clk);
         end
         repeat (3) @(negedge ref_clk);
         check(32'({rack_sel_n, cal_run}), 32'h7FFF);
      end
   endtask

   //////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      check(32'({busy, rack_sel_n, cal_run}), 32'hFFFF);
      bus(calrack_pkg::OFF_CTRL, 1'b0, 32'h0);
      check(rd, 32'h1);
      bus(8'h20, 1'b1, 32'hFFFFFFFF);
      bus(8'h20, 1'b0, 32'h0);
      check(rd, 32'h0);
      repeat (60) @(negedge ref_clk);
      check(32'(busy), 32'h0);
      for (int i = 0; i < 14; i++) begin
         c.mode = 2'(i % 3);
         c.rack = 6'(i);
         c.chan = 5'(2 * i + 1);
         do_cmd(c, 16'h0050, ~(14'h1 << i), 1'b1);
      end
      bus(calrack_pkg::OFF_LAST, 1'b0, 32'h0);
      check(rd, (32'(c.chan) << calrack_pkg::LAST_CHAN_LSB) |
         (32'(c.rack) << calrack_pkg::LAST_RACK_LSB) | 32'(c.mode));
      c.mode = 2'h3;
      c.rack = calrack_pkg::RACK_ALL;
      do_cmd(c, 16'h0050, 14'h0, 1'b1);
      c.mode = calrack_pkg::MODE_HIGH;
      c.rack = 6'h20;
      do_cmd(c, 16'h0050, 14'h3FFF, 1'b1);
      bus(calrack_pkg::OFF_MAP_INDEX, 1'b1, 32'h5);
      bus(calrack_pkg::OFF_MAP_DATA, 1'b1, 32'h0A05);
      bus(calrack_pkg::OFF_MAP_DATA, 1'b0, 32'h0);
      check(rd, 32'h0A05);
      c.mode = calrack_pkg::MODE_LOW;
      c.rack = 6'h05;
      do_cmd(c, 16'h0050, 14'h35FA, 1'b1);
      do_cmd(c, 16'h001E, 14'h3FFF, 1'b0);
      bus(calrack_pkg::OFF_CTRL, 1'b1, 32'h0);
      do_cmd(c, 16'h0050, 14'h3FFF, 1'b0);
      bus(calrack_pkg::OFF_CTRL, 1'b1, 32'h1);
      c.mode = calrack_pkg::MODE_HIGH;
      do_cmd(c, 16'h012C, 14'h35FA, 1'b1);
      // Soft clear reruns the clear stage
      bus(calrack_pkg::OFF_CTRL, 1'b1, 32'h3);
      repeat (3) @(negedge ref_clk);
      check(32'(busy), 32'h1);
      repeat (60) @(negedge ref_clk);
      check(32'(busy), 32'h0);
      // Second reset while the lines are driven
      @(posedge ref_clk);
      cmd_in <= c;
      hold_len <= 16'h00C8;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      repeat (70) @(negedge ref_clk);
      check(32'(rack_sel_n), 32'h35FA);
      @(posedge ref_clk);
      rst <= 1'b1;
      @(negedge ref_clk);
      check(32'({busy, rack_sel_n, cal_run}), 32'hFFFF);
      @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(negedge ref_clk);
      check(32'({busy, rack_sel_n, cal_run}), 32'hFFFF);
      complete_run;
   end
endmodule

bind calrack_sel calrack_sel_assertions #(.HOLD_CYC(HOLD_CYC)) chk (
   .ref_clk(ref_clk), .rst(rst), .cmd_present(cmd_present),
   .cal_cmd(cal_cmd), .rack_sel_n(rack_sel_n), .cal_high(cal_high),
   .cal_low(cal_low), .cal_run(cal_run), .chan_sel(chan_sel),
   .busy(busy));
